// ===== dv/lsc_host_model.sv
// Bus master model that drives the serial clock and data of the light sensor.
`timescale 1ns/1ps
`default_nettype none
module lsc_host_model (
  // Clock.
  input wire logic i_clk,
  // Serial bus.
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Six clocks per phase keep every level past the slave's synchroniser.
  task automatic hold();
    repeat (6) @(posedge i_clk);
  endtask

  task automatic start();
    hold();
    o_sda <= 1'b1;
    hold();
    o_scl <= 1'b1;
    hold();
    o_sda <= 1'b0;
    hold();
    o_scl <= 1'b0;
  endtask

  task automatic stop();
    hold();
    o_sda <= 1'b0;
    hold();
    o_scl <= 1'b1;
    hold();
    o_sda <= 1'b1;
    hold();
  endtask

  // Data changes only while the clock is low, a clock phase after its fall.
  task automatic put_bit(input logic b, output logic r);
    hold();
    o_sda <= b;
    hold();
    o_scl <= 1'b1;
    hold();
    r = i_sda;
    o_scl <= 1'b0;
  endtask

  // Eight bits out most significant first, then the ninth bit as given.
  task automatic put_byte(input logic [7:0] d, input logic last, output logic [7:0] q,
                          output logic nine);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], q[i]);
    end
    put_bit(last, nine);
  endtask

  // The command byte may carry the restart and clear bits; the caller spaces restarts.
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    input bit has_d, output logic nak);
    logic [7:0] q;
    logic n;
    start();
    put_byte({a, 1'b0}, 1'b1, q, nak);
    put_byte(c, 1'b1, q, n);
    if (has_d) begin
      put_byte(d, 1'b1, q, n);
    end
    stop();
  endtask

  // Pointer set by a command byte, then one byte read and refused with a high bit.
  task automatic rd(input logic [7:0] c, output logic [7:0] v);
    logic [7:0] q;
    logic n;
    start();
    put_byte({7'h44, 1'b0}, 1'b1, q, n);
    put_byte(c, 1'b1, q, n);
    start();
    put_byte({7'h44, 1'b1}, 1'b1, q, n);
    put_byte(8'hff, 1'b1, v, n);
    stop();
  endtask
endmodule // lsc_host_model
`default_nettype wire

// ===== dv/lsc_light_ctrl_tb.sv
// Self-checking bench for the light sensor control block.
`timescale 1ns/1ps
`default_nettype none
`include "lsc_regs.svh"
module lsc_light_ctrl_tb
  import lsc_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic osc = 1'b0;
  logic [15:0] light = 16'h0000;
  logic scl;
  logic host_sda;
  logic sda_out;
  logic sda_oe_n;
  logic int_out;
  logic int_oe_n;
  logic nak;
  logic [7:0] v;
  logic [7:0] t_lo;
  wire logic sda_wire;
  lsc_front_type front;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  // Address, written value and value read back.
  localparam logic [23:0] ROWS [10] = '{24'h00_7f6f, 24'h01_ff0f, 24'h02_a5a5, 24'h03_5a5a,
    24'h04_1200, 24'h07_3400, 24'h00_0000, 24'h01_0000, 24'h02_ffff, 24'h03_0000};

  always #4 clk = ~clk;
  always #32 osc = ~osc;
  // Pulled-up data line: low whenever either party pulls it.
  assign sda_wire = host_sda & (sda_oe_n | sda_out);

  lsc_light_ctrl u_dut (.i_clk(clk), .i_reset_n(reset_n), .i_scl(scl), .i_sda_in(sda_wire),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .o_int_out(int_out), .o_int_oe_n(int_oe_n),
    .i_osc(osc), .i_light_count(light), .o_front(front));
  lsc_host_model u_host (.i_clk(clk), .i_sda(sda_wire), .o_scl(scl), .o_sda(host_sda));

  task automatic finish_test();
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d, input bit has_d);
    u_host.wr(`LSC_SLAVE_ADDR, c, d, has_d, nak);
    chk("ack", 1'b0, nak);
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    u_host.rd({5'h00, a}, v);
    chk($sformatf("reg%0d", a), exp, v);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Bounded wait for the end of an integration; returns the cycles spent.
  task automatic wait_strobe(output int n);
    for (n = 0; n < 2500 && front.sample_strobe !== 1'b1; n++) begin
      @(posedge clk);
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    int n;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    waitc(4);
    for (int a = 0; a < 8; a++) begin
      rchk(a[2:0], (a == 2) ? 8'hff : 8'h00);
    end
    foreach (ROWS[i]) begin
      wr({5'h00, ROWS[i][18:16]}, ROWS[i][15:8], 1'b1);
      rchk(ROWS[i][18:16], ROWS[i][7:0]);
    end
    u_host.wr(7'h45, 8'h02, 8'h11, 1'b1, nak);
    chk("nak", 1'b1, nak);
    rchk(3'h2, 8'hff);
    // Negative reading sign-extends above the upper limit.
    light <= 16'h0043;
    wr(8'h00, 8'h8a, 1'b1);
    chk("core_reset", 1'b0, front.core_reset);
    wait_strobe(n);
    chk("strobe", 1'b1, front.sample_strobe);
    waitc(2);
    chk("int_pin", 1'b0, int_oe_n);
    chk("int_out", 1'b0, int_out);
    wait_strobe(n);
    waitc(1);
    wait_strobe(n);
    chk("period", 1'b1, n > 2040 && n < 2056);
    rchk(3'h4, 8'hc3);
    rchk(3'h5, 8'hff);
    rchk(3'h1, 8'h20);
    light <= 16'h0010;
    wr(8'h40, 8'h00, 1'b0);
    waitc(2);
    chk("int_pin", 1'b1, int_oe_n);
    rchk(3'h1, 8'h00);
    wr(8'h01, 8'h01, 1'b1);
    wr(8'h03, 8'h01, 1'b1);
    waitc(5000);
    chk("int_early", 1'b1, int_oe_n);
    for (n = 0; n < 4000 && int_oe_n !== 1'b0; n++) begin
      @(posedge clk);
    end
    chk("int_late", 1'b0, int_oe_n);
    wr(8'h03, 8'h00, 1'b1);
    wr(8'h01, 8'h00, 1'b1);
    rchk(3'h1, 8'h00);
    chk("int_pin", 1'b1, int_oe_n);
    wr(8'h80, 8'haa, 1'b1);
    waitc(1000);
    wr(8'h80, 8'h00, 1'b0);
    rchk(3'h4, 8'h10);
    u_host.rd(8'h06, v);
    t_lo = v;
    u_host.rd(8'h07, v);
    chk("timer", 1'b1, {v, t_lo} > 16'h007d && {v, t_lo} < 16'h012c);
    wr(8'h00, 8'h87, 1'b1);
    wait_strobe(n);
    chk("no_strobe", 1'b0, front.sample_strobe);
    wr(8'h00, 8'h4a, 1'b1);
    chk("core_reset", 1'b1, front.core_reset);
    chk("power_down", 1'b1, front.power_down);
    wr(8'h01, 8'h0c, 1'b1);
    chk("range", 2'h3, front.range_select);
    // A second reset, with the converter powered down, must bring the front outputs, the alert pin and registers 0 and 2 back to their defaults.
    reset_n <= 1'b0;
    waitc(2);
    chk("rst_core", 1'b1, front.core_reset);
    chk("rst_pd", 1'b0, front.power_down);
    chk("rst_range", 2'h0, front.range_select);
    chk("rst_int", 1'b1, int_oe_n);
    reset_n <= 1'b1;
    waitc(4);
    rchk(3'h0, 8'h00);
    rchk(3'h2, 8'hff);
    finish_test();
  end
endmodule // lsc_light_ctrl_tb
`default_nettype wire

// ===== src/lsc_light_ctrl.sv
// Serial slave, registers, integration timing and threshold alert of the light sensor.
`timescale 1ns/1ps
`default_nettype none
`include "lsc_regs.svh"
// Operation
// - Answer only the fixed seven-bit slave address.
// - Command byte top bit restarts the integration.
// - Command byte bit six clears the interrupt.
// - Enable bit low holds converter core reset.
// - Power-down bit stops integration; the bus still answers.
// - Timing bit picks internal or host timing.
// - Host timing: period runs sync to sync.
// - Width code sets oscillator cycles per conversion.
// - Only photodiode code two yields light counts.
// - Result is signed, one bit below width.
// - Flag reads one once the alert fired.
// - Writing zero to the flag clears it.
// - Range code selects one of four ranges.
// - Alert after m consecutive out-of-window integrations.
// - Upper limit is high byte, resets ones.
// - Lower limit is high byte, resets zero.
// - Every integration end refreshes the sensor data.
// - Open-drain alert pin stays low until cleared.
// - Host timing latches the cycle count as timer.
// - Low address holds the reading's low byte.
module lsc_light_ctrl
  import lsc_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Serial bus pins.
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  // Alert pin.
  output logic o_int_out,
  output logic o_int_oe_n,
  // Oscillator and converter core.
  input wire logic i_osc,
  input wire logic [15:0] i_light_count,
  output lsc_front_type o_front
);
  lsc_state_type state;
  lsc_cmd_type cmd;
  lsc_ctrl_type ctrl;
  logic [2:0] pins_s;
  logic osc_s, scl_s, sda_s, osc_d, scl_d, sda_d;
  logic scl_rise, scl_fall, start, stop, osc_tick;
  logic [3:0] bitcnt;
  logic [7:0] shreg, txbyte, rd_byte, hi_lim, lo_lim;
  logic [1:0] phase, wsel;
  logic [2:0] ptr;
  logic rw, master_ack, addr_ok, byte_done, cmd_strobe, wr_strobe, tx_load;
  logic sync_cmd, run, hold_reset, ext, int_end, out_win, int_set, int_clr;
  logic [15:0] cyc_cnt, sensor, timer, sample_val;
  logic [4:0] pcnt, next_pcnt, persist_m;

  function automatic logic [15:0] last_cycle(input logic [1:0] w);
    unique case (w)
      2'h0: last_cycle = `LSC_LAST_W0;
      2'h1: last_cycle = `LSC_LAST_W1;
      2'h2: last_cycle = `LSC_LAST_W2;
      2'h3: last_cycle = `LSC_LAST_W3;
    endcase
  endfunction

  // Sign-extends the raw count from the top bit of the selected result width.
  function automatic logic [15:0] trim(input logic [15:0] raw, input logic [1:0] w);
    unique case (w)
      2'h0: trim = {{1{raw[14]}}, raw[14:0]};
      2'h1: trim = {{5{raw[10]}}, raw[10:0]};
      2'h2: trim = {{9{raw[6]}}, raw[6:0]};
      2'h3: trim = {{13{raw[2]}}, raw[2:0]};
    endcase
  endfunction

  function automatic logic [4:0] persist_of(input logic [1:0] p);
    unique case (p)
      2'h0: persist_of = `LSC_PERSIST_P0;
      2'h1: persist_of = `LSC_PERSIST_P1;
      2'h2: persist_of = `LSC_PERSIST_P2;
      2'h3: persist_of = `LSC_PERSIST_P3;
    endcase
  endfunction

  lsc_sync u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_osc, i_scl, i_sda_in}),
    .o_sync(pins_s)
  );

  assign osc_s = pins_s[2];
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {osc_d, scl_d, sda_d} <= `LSC_SYNC_RST;
    end else begin
      {osc_d, scl_d, sda_d} <= pins_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start = scl_s & scl_d & sda_d & ~sda_s;
  assign stop = scl_s & scl_d & ~sda_d & sda_s;
  assign osc_tick = osc_s & ~osc_d;

  assign addr_ok = (shreg[7:1] == `LSC_SLAVE_ADDR);
  assign byte_done = (state == ST_RX) && scl_fall && (bitcnt == `LSC_BYTE_BITS);
  assign cmd_strobe = byte_done && (phase == `LSC_PH_CMD);
  assign wr_strobe = byte_done && (phase == `LSC_PH_DATA);
  assign tx_load = scl_fall && (((state == ST_ACK) && rw) || ((state == ST_TACK) && master_ack));

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
      bitcnt <= '0;
      shreg <= '0;
      txbyte <= '0;
      phase <= `LSC_PH_ADDR;
      rw <= 1'b0;
      master_ack <= 1'b0;
    end else if (start) begin
      state <= ST_RX;
      bitcnt <= '0;
      phase <= `LSC_PH_ADDR;
    end else if (stop) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
        end
        ST_RX: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end
          if (byte_done) begin
            bitcnt <= '0;
            if (phase == `LSC_PH_ADDR) begin
              rw <= shreg[0];
              state <= addr_ok ? ST_ACK : ST_IDLE;
            end else begin
              state <= ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state <= rw ? ST_TX : ST_RX;
            txbyte <= rd_byte;
            if (phase != `LSC_PH_DATA) begin
              phase <= phase + 2'h1;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            txbyte <= {txbyte[6:0], 1'b0};
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt == `LSC_TX_LAST) begin
              state <= ST_TACK;
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            master_ack <= ~sda_s;
          end
          if (scl_fall) begin
            bitcnt <= '0;
            txbyte <= rd_byte;
            state <= master_ack ? ST_TX : ST_IDLE;
          end
        end
      endcase
    end
  end

  // The register pointer steps after every data byte so that bursts walk the map.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ptr <= `LSC_ADR_CMD;
    end else if (cmd_strobe) begin
      ptr <= shreg[2:0];
    end else if (wr_strobe || tx_load) begin
      ptr <= ptr + 3'h1;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe_n = !((state == ST_ACK) || ((state == ST_TX) && !txbyte[7]));

  always_comb begin
    unique case (ptr)
      `LSC_ADR_CMD: rd_byte = cmd & `LSC_CMD_MASK;
      `LSC_ADR_CTRL: rd_byte = ctrl & `LSC_CTRL_RMASK;
      `LSC_ADR_HI: rd_byte = hi_lim;
      `LSC_ADR_LO: rd_byte = lo_lim;
      `LSC_ADR_SNS_L: rd_byte = sensor[7:0];
      `LSC_ADR_SNS_H: rd_byte = sensor[15:8];
      `LSC_ADR_TMR_L: rd_byte = timer[7:0];
      `LSC_ADR_TMR_H: rd_byte = timer[15:8];
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd <= lsc_cmd_type'(`LSC_CMD_RST);
    end else if (wr_strobe && (ptr == `LSC_ADR_CMD)) begin
      cmd <= lsc_cmd_type'(shreg & `LSC_CMD_MASK);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hi_lim <= `LSC_HI_RST;
      lo_lim <= `LSC_LO_RST;
    end else if (wr_strobe && (ptr == `LSC_ADR_HI)) begin
      hi_lim <= shreg;
    end else if (wr_strobe && (ptr == `LSC_ADR_LO)) begin
      lo_lim <= shreg;
    end
  end

  assign int_clr = (cmd_strobe && shreg[`LSC_CMD_CLR_BIT])
                   || (wr_strobe && (ptr == `LSC_ADR_CTRL) && !shreg[`LSC_FLAG_BIT]);

  // A new alert in the same cycle as a clear keeps the flag set.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl <= lsc_ctrl_type'(`LSC_CTRL_RST);
    end else begin
      if (wr_strobe && (ptr == `LSC_ADR_CTRL)) begin
        ctrl <= lsc_ctrl_type'(shreg & `LSC_CTRL_WMASK);
      end
      ctrl.int_flag <= int_set | (ctrl.int_flag & ~int_clr);
    end
  end

  assign o_int_out = 1'b0;
  assign o_int_oe_n = ~ctrl.int_flag;

  assign ext = cmd.timing_select;
  assign wsel = {cmd.width_select_hi, cmd.width_select_lo};
  assign hold_reset = !cmd.converter_enable || !cmd.photodiode_select_hi;
  assign run = cmd.converter_enable && !cmd.power_down_bit
               && ({cmd.photodiode_select_hi, cmd.photodiode_select_lo} == `LSC_PD_LIGHT);
  assign sync_cmd = cmd_strobe && shreg[`LSC_CMD_SYNC_BIT];
  assign int_end = run && (ext ? sync_cmd
                   : (osc_tick && (cyc_cnt == last_cycle(wsel))));

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cyc_cnt <= '0;
    end else if (hold_reset || int_end || sync_cmd) begin
      cyc_cnt <= '0;
    end else if (run && osc_tick) begin
      cyc_cnt <= cyc_cnt + 16'h0001;
    end
  end

  assign sample_val = trim(i_light_count, wsel);
  assign out_win = (sample_val > {hi_lim, `LSC_LIM_LOW_BYTE})
                   || (sample_val < {lo_lim, `LSC_LIM_LOW_BYTE});

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sensor <= `LSC_DATA_RST;
      timer <= `LSC_DATA_RST;
    end else if (int_end) begin
      sensor <= sample_val;
      if (ext) begin
        timer <= cyc_cnt;
      end
    end
  end

  assign persist_m = persist_of({ctrl.persist_count_hi, ctrl.persist_count_lo});
  assign next_pcnt = pcnt + 5'h01;
  assign int_set = int_end && out_win && (next_pcnt >= persist_m);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pcnt <= '0;
    end else if (hold_reset || (int_end && !out_win)) begin
      pcnt <= '0;
    end else if (int_end && (next_pcnt <= persist_m)) begin
      pcnt <= next_pcnt;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_front <= lsc_front_type'(`LSC_FRONT_RST);
    end else begin
      o_front.core_reset <= hold_reset;
      o_front.power_down <= cmd.power_down_bit;
      o_front.range_select <= {ctrl.range_select_hi, ctrl.range_select_lo};
      o_front.sample_strobe <= int_end;
    end
  end

  property p_addr_miss;
    @(posedge i_clk) disable iff (!i_reset_n)
      byte_done && (phase == `LSC_PH_ADDR) && !addr_ok && !start && !stop |=> state == ST_IDLE;
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("Foreign address was acknowledged.");

  property p_sync;
    @(posedge i_clk) disable iff (!i_reset_n)
      sync_cmd && run && ext |=> (cyc_cnt == '0) && o_front.sample_strobe;
  endproperty
  a_sync: assert property (p_sync)
    else $error("Sync command did not end the integration.");

  property p_clear;
    @(posedge i_clk) disable iff (!i_reset_n)
      int_clr && !int_set |=> !ctrl.int_flag && o_int_oe_n;
  endproperty
  a_clear: assert property (p_clear)
    else $error("Clear left the alert flag set.");

  property p_hold;
    @(posedge i_clk) disable iff (!i_reset_n)
      !cmd.converter_enable |=> o_front.core_reset && (cyc_cnt == '0);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Disabled converter was not held in reset.");

  property p_internal;
    @(posedge i_clk) disable iff (!i_reset_n)
      run && !ext && osc_tick && (cyc_cnt == last_cycle(wsel)) |=> o_front.sample_strobe;
  endproperty
  a_internal: assert property (p_internal)
    else $error("Internal integration did not end on its last cycle.");

  property p_update;
    @(posedge i_clk) disable iff (!i_reset_n)
      int_end |=> sensor == $past(sample_val);
  endproperty
  a_update: assert property (p_update)
    else $error("Sensor data not refreshed at integration end.");

  property p_rise;
    @(posedge i_clk) disable iff (!i_reset_n)
      $rose(ctrl.int_flag) |-> $past(int_end) && $past(out_win);
  endproperty
  a_rise: assert property (p_rise)
    else $error("Alert flag rose without an out-of-window result.");

  property p_sticky;
    @(posedge i_clk) disable iff (!i_reset_n)
      ctrl.int_flag && !int_clr |=> ctrl.int_flag && !o_int_oe_n;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Alert pin released without a clear.");

  property p_inwin;
    @(posedge i_clk) disable iff (!i_reset_n)
      int_end && !out_win |=> (pcnt == '0) && !$rose(ctrl.int_flag);
  endproperty
  a_inwin: assert property (p_inwin)
    else $error("In-window result did not restart persistence.");

  property p_keep;
    @(posedge i_clk) disable iff (!i_reset_n)
      !(wr_strobe && (ptr == `LSC_ADR_CMD)) |=> $stable(cmd);
  endproperty
  a_keep: assert property (p_keep)
    else $error("Command register changed without a write.");
endmodule // lsc_light_ctrl
`default_nettype wire

// ===== src/lsc_pkg.sv
// Types shared by the light sensor control design.
package lsc_pkg;
  typedef struct packed {
    logic converter_enable;
    logic power_down_bit;
    logic timing_select;
    logic spare;
    logic photodiode_select_hi;
    logic photodiode_select_lo;
    logic width_select_hi;
    logic width_select_lo;
  } lsc_cmd_type;

  typedef struct packed {
    logic [1:0] spare_hi;
    logic int_flag;
    logic spare;
    logic range_select_hi;
    logic range_select_lo;
    logic persist_count_hi;
    logic persist_count_lo;
  } lsc_ctrl_type;

  typedef struct packed {
    logic core_reset;
    logic power_down;
    logic [1:0] range_select;
    logic sample_strobe;
  } lsc_front_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_TACK = 5'h10
  } lsc_state_type;
endpackage

// ===== src/lsc_regs.svh
// Register offsets, reset values, field positions and counts of the light sensor control.
`ifndef LSC_REGS_SVH
`define LSC_REGS_SVH
`define LSC_SLAVE_ADDR 7'h44
`define LSC_ADR_CMD 3'h0
`define LSC_ADR_CTRL 3'h1
`define LSC_ADR_HI 3'h2
`define LSC_ADR_LO 3'h3
`define LSC_ADR_SNS_L 3'h4
`define LSC_ADR_SNS_H 3'h5
`define LSC_ADR_TMR_L 3'h6
`define LSC_ADR_TMR_H 3'h7
`define LSC_CMD_RST 8'h00
`define LSC_CTRL_RST 8'h00
`define LSC_HI_RST 8'hff
`define LSC_LO_RST 8'h00
`define LSC_DATA_RST 16'h0000
`define LSC_FRONT_RST 5'h10
`define LSC_SYNC_RST 3'h3
`define LSC_CMD_MASK 8'hef
`define LSC_CTRL_WMASK 8'h0f
`define LSC_CTRL_RMASK 8'h2f
`define LSC_CMD_SYNC_BIT 7
`define LSC_CMD_CLR_BIT 6
`define LSC_FLAG_BIT 5
`define LSC_LIM_LOW_BYTE 8'h00
`define LSC_PD_LIGHT 2'h2
`define LSC_LAST_W0 16'hffff
`define LSC_LAST_W1 16'h0fff
`define LSC_LAST_W2 16'h00ff
`define LSC_LAST_W3 16'h000f
`define LSC_PERSIST_P0 5'h01
`define LSC_PERSIST_P1 5'h04
`define LSC_PERSIST_P2 5'h08
`define LSC_PERSIST_P3 5'h10
`define LSC_BYTE_BITS 4'h8
`define LSC_TX_LAST 4'h7
`define LSC_PH_ADDR 2'h0
`define LSC_PH_CMD 2'h1
`define LSC_PH_DATA 2'h2
`endif

// ===== src/lsc_sync.sv
// Two-stage synchroniser for the bus pins and the oscillator input.
`timescale 1ns/1ps
`default_nettype none
`include "lsc_regs.svh"
module lsc_sync
  import lsc_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Asynchronous levels and their synchronised copies.
  input wire logic [2:0] i_async,
  output logic [2:0] o_sync
);
  logic [2:0] meta;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta <= `LSC_SYNC_RST;
      o_sync <= `LSC_SYNC_RST;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // lsc_sync
`default_nettype wire
